// ==== qws_link.sv ====
// Shared constants for the quad wiper serial slave, and its serial-clock
// side: bit capture, byte framing and the open-drain data drive.
// Assumes the serial clock runs only inside frames; frame clear comes
// from a ref_clk-domain flip-flop.
`timescale 1ns/1ps
`default_nettype none

package qws_pkg;
	localparam int NUM_CHAN = 4;
	localparam int NUM_STORE = 4;
	localparam int TAP_W = 8;
	localparam int CLK_PERIOD_NS = 4;
	localparam int NV_WRITE_NS = 10_000_000;
	localparam int NV_WRITE_CYC = NV_WRITE_NS / CLK_PERIOD_NS;
	localparam int BUSY_CNT_W = 24;
	localparam logic [3:0] BIT_LAST = 4'h8;
	localparam logic [3:0] BIT_BYTE = 4'h7;
	localparam logic [3:0] OP_RD_WIPER = 4'h9;
	localparam logic [3:0] OP_WR_WIPER = 4'ha;
	localparam logic [3:0] OP_RD_STORE = 4'hb;
	localparam logic [3:0] OP_WR_STORE = 4'hc;
	localparam logic [1:0] RECALL_IDX = 2'h0;
	localparam int SY_SCL = 0;
	localparam int SY_SDA = 1;
	localparam int SY_WP = 2;
	localparam int SY_RXT = 3;
	localparam int SY_ACKT = 4;
	localparam int SY_ADDR = 5;
	localparam int SY_W = 9;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ID,
		ST_INSTR,
		ST_WDATA,
		ST_RDATA
	} qws_state_e;
endpackage

module qws_link (
	input wire logic scl_clk,
	input wire logic frm_clr,
	input wire logic lnk_rst,
	input wire logic sda_i,
	input wire logic ack_en,
	input wire logic tx_mode,
	input wire logic [7:0] tx_byte,
	output logic [7:0] rx_byte,
	output logic rx_tgl,
	output logic mack,
	output logic ack_tgl,
	output logic sda_oe
);
	logic [3:0] cnt_q;
	logic [6:0] sh_q;
	logic [7:0] rx_byte_q;
	logic rx_tgl_q, mack_q, ack_tgl_q, oe_q;
	wire logic [2:0] tx_idx = 3'h7 - cnt_q[2:0];
	wire logic bit_last = (cnt_q == qws_pkg::BIT_LAST);

	assign rx_byte = rx_byte_q;
	assign rx_tgl = rx_tgl_q;
	assign mack = mack_q;
	assign ack_tgl = ack_tgl_q;
	assign sda_oe = oe_q;

	////////////////////////////////////////////////////////////////////////
	// Bit position within the nine-clock byte slot
	always_ff @(posedge scl_clk or posedge frm_clr) begin
		if (frm_clr)
			cnt_q <= 4'h0;
		else
			cnt_q <= bit_last ? 4'h0 : cnt_q + 4'h1;
	end

	// Bits taken on the rising serial clock edge [RL4]
	always_ff @(posedge scl_clk or posedge lnk_rst) begin
		if (lnk_rst) begin
			sh_q <= 7'h00;
			rx_byte_q <= 8'h00;
			rx_tgl_q <= 1'b0;
			mack_q <= 1'b0;
			ack_tgl_q <= 1'b0;
		end else begin
			sh_q <= {sh_q[5:0], sda_i}; // [RL4]
			if (cnt_q == qws_pkg::BIT_BYTE && !frm_clr) begin
				rx_byte_q <= {sh_q, sda_i};
				rx_tgl_q <= ~rx_tgl_q;
			end
			if (bit_last && !frm_clr) begin
				mack_q <= ~sda_i;
				ack_tgl_q <= ~ack_tgl_q;
			end
		end
	end

	// Pull-down only, changed after the falling edge [RL5] [RL6]
	always_ff @(negedge scl_clk or posedge frm_clr) begin
		if (frm_clr)
			oe_q <= 1'b0;
		else if (bit_last)
			oe_q <= ack_en; // [RL13]
		else
			oe_q <= tx_mode & ~tx_byte[tx_idx]; // [RL5]
	end
endmodule // qws_link

`default_nettype wire

// ==== qws_top.sv ====
// Quad wiper serial slave: ref_clk-domain control, wiper and stored
// settings, frame detection and the nonvolatile write busy time.
// Assumes a two-wire master drives scl_clk and a pull-up on the data wire.
//
// Functional notes
// RL1 - Four channels, each one wiper register and four stored settings.
// RL2 - Each 8-bit wiper value picks one of 256 taps.
// RL3 - After reset each wiper loads its channel's stored setting zero.
// RL4 - Incoming serial bits are sampled on the rising serial clock edge.
// RL5 - Returned data changes only after a falling serial clock edge.
// RL6 - Data line is only pulled low or released, never driven high.
// RL7 - Address pins give the low four bits of the slave address.
// RL8 - Device stays passive unless the received address matches.
// RL9 - The master makes the serial clock; the device only receives it.
// RL10 - At most sixteen such devices per bus, distinct address pins.
// RL11 - Write-lock input low refuses every stored-setting write.
// RL12 - First byte accepted only with device type and pin match.
// RL13 - Acknowledge after valid address, instruction and each write byte.
// RL14 - During a stored write, lines are ignored and address not acked.
// RL15 - Each wiper register appears directly as an 8-bit tap output.
`timescale 1ns/1ps
`default_nettype none

module qws_top #(
	parameter logic [3:0] DEV_TYPE_ID = 4'ha, // Arbitrary value
	parameter int NV_WRITE_CYC = qws_pkg::NV_WRITE_CYC,
	parameter logic [7:0] STORE_INIT = 8'h80
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic scl_clk,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic [3:0] addr_select_pins,
	input wire logic wr_lock_n,
	output logic [qws_pkg::NUM_CHAN-1:0][qws_pkg::TAP_W-1:0] tap_sel,
	output logic nv_busy
);
	if (NV_WRITE_CYC < 1 || NV_WRITE_CYC >= (1 << qws_pkg::BUSY_CNT_W))
		$error("NV_WRITE_CYC out of range");

	localparam logic [qws_pkg::BUSY_CNT_W-1:0] BUSY_LAST =
		qws_pkg::BUSY_CNT_W'(NV_WRITE_CYC - 1);

	logic [qws_pkg::SY_W-1:0] s1_q, s2_q, p_q;
	qws_pkg::qws_state_e state_q;
	logic ack_en_q, tx_mode_q, frm_clr_q, arm_q, lnk_rst_q;
	logic busy_q, nv_pend_q, pwrup_q;
	logic [7:0] tx_byte_q;
	logic [3:0] op_q;
	logic [1:0] ptr_q, ch_q;
	logic [qws_pkg::BUSY_CNT_W-1:0] busy_cnt_q;
	logic [qws_pkg::NUM_CHAN-1:0][qws_pkg::TAP_W-1:0] wiper_position_reg_q;
	logic [qws_pkg::NUM_CHAN-1:0][qws_pkg::NUM_STORE-1:0][7:0]
		stored_setting_reg_q;
	logic [7:0] rx_byte;
	logic rx_tgl, mack, ack_tgl, link_oe;

	////////////////////////////////////////////////////////////////////////
	// Pin and toggle synchronisers; only s2_q and p_q feed logic
	wire logic [qws_pkg::SY_W-1:0] sy_in = {addr_select_pins, ack_tgl,
		rx_tgl, wr_lock_n, sda_i, scl_clk};

	always_ff @(posedge ref_clk) begin
		s1_q <= sy_in;
		s2_q <= s1_q;
		p_q <= s2_q;
	end

	wire logic scl_s = s2_q[qws_pkg::SY_SCL];
	wire logic sda_s = s2_q[qws_pkg::SY_SDA];
	wire logic sda_p = p_q[qws_pkg::SY_SDA];
	wire logic wp_ok = s2_q[qws_pkg::SY_WP];
	wire logic [3:0] addr_s = s2_q[qws_pkg::SY_ADDR +: 4]; // [RL7]
	wire logic start_ev = scl_s & sda_p & ~sda_s;
	wire logic stop_ev = scl_s & ~sda_p & sda_s;
	wire logic rx_ev = s2_q[qws_pkg::SY_RXT] ^ p_q[qws_pkg::SY_RXT];
	wire logic ack_ev = s2_q[qws_pkg::SY_ACKT] ^ p_q[qws_pkg::SY_ACKT];

	////////////////////////////////////////////////////////////////////////
	// Byte decode
	wire logic id_ok = (rx_byte == {DEV_TYPE_ID, addr_s}); // [RL12] [RL8]
	wire logic [3:0] op_in = rx_byte[7:4];
	wire logic [1:0] ptr_in = rx_byte[3:2];
	wire logic [1:0] ch_in = rx_byte[1:0];
	wire logic op_rd = (op_in == qws_pkg::OP_RD_WIPER) ||
		(op_in == qws_pkg::OP_RD_STORE);
	wire logic op_wr = (op_in == qws_pkg::OP_WR_WIPER) ||
		(op_in == qws_pkg::OP_WR_STORE);

	function automatic logic [7:0] rd_sel(input logic [3:0] op,
		input logic [1:0] ch, input logic [1:0] ptr);
		if (op == qws_pkg::OP_RD_WIPER)
			return wiper_position_reg_q[ch];
		else
			return stored_setting_reg_q[ch][ptr];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Frame gate for the serial-clock side; held while busy [RL14]
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			frm_clr_q <= 1'b1;
			arm_q <= 1'b0;
			lnk_rst_q <= 1'b1;
		end else begin
			lnk_rst_q <= 1'b0;
			if (busy_q || stop_ev) begin
				frm_clr_q <= 1'b1; // [RL14]
				arm_q <= 1'b0;
			end else if (start_ev) begin
				frm_clr_q <= 1'b1;
				arm_q <= 1'b1;
			end else if (arm_q && !scl_s) begin
				frm_clr_q <= 1'b0;
				arm_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Stored write busy time, started by the stop that ends the write
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			busy_q <= 1'b0;
			busy_cnt_q <= '0;
		end else if (busy_q) begin
			busy_q <= (busy_cnt_q != BUSY_LAST);
			busy_cnt_q <= busy_cnt_q + 1'b1;
		end else if (stop_ev && nv_pend_q) begin
			busy_q <= 1'b1; // [RL14]
			busy_cnt_q <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Protocol control and register file [RL1]
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			state_q <= qws_pkg::ST_IDLE;
			ack_en_q <= 1'b0;
			tx_mode_q <= 1'b0;
			tx_byte_q <= 8'h00;
			op_q <= 4'h0;
			ptr_q <= 2'h0;
			ch_q <= 2'h0;
			nv_pend_q <= 1'b0;
			pwrup_q <= 1'b1;
			wiper_position_reg_q <= '0;
			stored_setting_reg_q <= {16{STORE_INIT}};
		end else begin
			pwrup_q <= 1'b0;
			if (pwrup_q)
				for (int i = 0; i < qws_pkg::NUM_CHAN; i++)
					wiper_position_reg_q[i] <=
						stored_setting_reg_q[i][qws_pkg::RECALL_IDX]; // [RL3]
			if (stop_ev)
				nv_pend_q <= 1'b0;
			if (start_ev) begin
				state_q <= qws_pkg::ST_ID;
				ack_en_q <= 1'b0;
				tx_mode_q <= 1'b0;
			end else if (stop_ev) begin
				state_q <= qws_pkg::ST_IDLE;
				ack_en_q <= 1'b0;
				tx_mode_q <= 1'b0;
			end else if (rx_ev) begin
				case (state_q)
				qws_pkg::ST_ID: begin
					ack_en_q <= id_ok && !busy_q; // [RL8] [RL14] [RL13]
					state_q <= (id_ok && !busy_q) ? qws_pkg::ST_INSTR :
						qws_pkg::ST_IDLE;
				end
				qws_pkg::ST_INSTR: begin
					ack_en_q <= op_rd || op_wr; // [RL13]
					op_q <= op_in;
					ptr_q <= ptr_in;
					ch_q <= ch_in;
					tx_mode_q <= op_rd;
					tx_byte_q <= rd_sel(op_in, ch_in, ptr_in);
					if (op_rd)
						state_q <= qws_pkg::ST_RDATA;
					else if (op_wr)
						state_q <= qws_pkg::ST_WDATA;
					else
						state_q <= qws_pkg::ST_IDLE;
				end
				qws_pkg::ST_WDATA: begin
					ack_en_q <= 1'b1; // [RL13]
					if (op_q == qws_pkg::OP_WR_WIPER)
						wiper_position_reg_q[ch_q] <= rx_byte; // [RL2]
					else if (wp_ok) begin
						stored_setting_reg_q[ch_q][ptr_q] <= rx_byte; // [RL11]
						nv_pend_q <= 1'b1;
					end
				end
				default: ack_en_q <= 1'b0;
				endcase
			end else if (ack_ev && state_q == qws_pkg::ST_RDATA) begin
				if (mack)
					tx_byte_q <= rd_sel(op_q, ch_q, ptr_q);
				else begin
					tx_mode_q <= 1'b0;
					state_q <= qws_pkg::ST_IDLE;
				end
			end
		end
	end

	qws_link u_link (
		.scl_clk(scl_clk), // [RL9]
		.frm_clr(frm_clr_q),
		.lnk_rst(lnk_rst_q),
		.sda_i(sda_i),
		.ack_en(ack_en_q),
		.tx_mode(tx_mode_q),
		.tx_byte(tx_byte_q),
		.rx_byte(rx_byte),
		.rx_tgl(rx_tgl),
		.mack(mack),
		.ack_tgl(ack_tgl),
		.sda_oe(link_oe)
	);

	assign sda_o = 1'b0; // [RL6]
	assign sda_oe = link_oe;
	assign tap_sel = wiper_position_reg_q; // [RL15] [RL2]
	assign nv_busy = busy_q;
endmodule // qws_top

`default_nettype wire

// ==== qws_top_monitor.sv ====
// Port checker for the quad wiper serial slave top.
// Assumes a bind from the bench top that hands on STORE_INIT.
`timescale 1ns/1ps
`default_nettype none
module qws_top_monitor #(
	parameter logic [7:0] STORE_INIT = 8'h80
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic scl_clk,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic wr_lock_n,
	input wire logic [qws_pkg::NUM_CHAN-1:0][qws_pkg::TAP_W-1:0] tap_sel,
	input wire logic nv_busy
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	sequence locked_s;
		!wr_lock_n [*4];
	endsequence
	sequence busy_s;
		nv_busy [*2];
	endsequence
	pull_low_a: assert property (sda_o == 1'b0)
		else $error("data driven high");
	oe_after_fall_a: assert property ($changed(sda_oe) |-> !scl_clk)
		else $error("drive moved with clock high");
	busy_mute_a: assert property (nv_busy |-> !sda_oe)
		else $error("drive while busy");
	busy_hold_a: assert property (busy_s |-> $stable(tap_sel))
		else $error("wiper moved while busy");
	lock_refuse_a: assert property (locked_s |-> !$rose(nv_busy))
		else $error("busy began while locked");
	busy_at_stop_a: assert property ($rose(nv_busy) |-> scl_clk)
		else $error("busy began outside a stop");
	reset_clear_a: assert property (disable iff (1'b0)
		!rstn |=> tap_sel == '0 && !nv_busy) else $error("reset not clean");
	wiper_recall_a: assert property (disable iff (1'b0)
		$rose(rstn) |=> tap_sel == {4{STORE_INIT}}) else $error("no recall");
endmodule // qws_top_monitor
`default_nettype wire

// ==== qws_master.sv ====
// Two-wire bus master model: serial clock and data pull-down.
// Assumes a pull-up resolves the data wire outside this model.
`timescale 1ns/1ps
`default_nettype none
module qws_master (
	output logic scl_clk,
	output logic pull_low,
	input wire logic sda_i
);
	initial begin
		scl_clk = 1'b1;
		pull_low = 1'b0;
	end
	task automatic start();
		#1.3 pull_low = 1'b1;
		#40 scl_clk = 1'b0;
	endtask
	task automatic stop();
		#10 pull_low = 1'b1;
		#30 scl_clk = 1'b1;
		#40 pull_low = 1'b0;
		#40;
	endtask
	// Data set only while the clock is low
	task automatic bit_x(input logic b, output logic s);
		#10 pull_low = !b;
		#30 scl_clk = 1'b1;
		s = sda_i;
		#40 scl_clk = 1'b0;
	endtask
	task automatic byte_x(input logic [7:0] d, input logic ak,
		output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], q[i]);
		bit_x(ak, ack);
	endtask
endmodule // qws_master
`default_nettype wire

// ==== qws_top_tb_top.sv ====
// Bench top for the quad wiper serial slave.
// Assumes the master model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module qws_top_tb_top;
	localparam logic [3:0] DEV_ID = 4'ha;
	localparam logic [7:0] INIT = 8'h80;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic [3:0] addr_select_pins = 4'h0;
	logic wr_lock_n = 1'b1;
	logic scl_clk, pull_low, sda_o, sda_oe, nv_busy, ak;
	logic [3:0][7:0] tap_sel;
	logic [7:0] q, d;
	wire logic sda_i = !(pull_low || sda_oe);
	int fail_count = 0;
	int n_checks = 0;
	always #2 ref_clk = !ref_clk;
	qws_top #(.DEV_TYPE_ID(DEV_ID), .NV_WRITE_CYC(400), .STORE_INIT(INIT))
		u_qws_top (.ref_clk(ref_clk), .rstn(rstn), .scl_clk(scl_clk),
		.sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
		.addr_select_pins(addr_select_pins), .wr_lock_n(wr_lock_n),
		.tap_sel(tap_sel), .nv_busy(nv_busy));
	qws_master u_qws_master (.scl_clk(scl_clk), .pull_low(pull_low),
		.sda_i(sda_i));
	function automatic logic [7:0] id_of(input logic [3:0] a);
		return {DEV_ID, a};
	endfunction
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] s);
		n_checks++;
		if (s !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
			fail_count++;
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic probe_id(input logic [7:0] id, input logic nak);
		u_qws_master.start();
		u_qws_master.byte_x(id, 1'b1, q, ak);
		chk("id refused", {7'h0, nak}, {7'h0, ak});
		u_qws_master.stop();
	endtask
	// Id, instruction, then one data byte written or read
	task automatic xfer(input logic [7:0] ins, input logic [7:0] wd,
		input logic rd, output logic [7:0] rq);
		u_qws_master.start();
		u_qws_master.byte_x(id_of(addr_select_pins), 1'b1, rq, ak);
		chk("id ack", 8'h0, {7'h0, ak});
		u_qws_master.byte_x(ins, 1'b1, rq, ak);
		chk("instr ack", 8'h0, {7'h0, ak});
		u_qws_master.byte_x(rd ? 8'hff : wd, 1'b1, rq, ak);
		if (!rd)
			chk("data ack", 8'h0, {7'h0, ak});
		u_qws_master.stop();
	endtask
	initial begin
		void'($urandom(32'hc237741f));
		repeat (20) @(negedge ref_clk);
		rstn = 1'b1;
		repeat (6) @(negedge ref_clk);
		for (int c = 0; c < 4; c++)
			chk("recall", INIT, tap_sel[c]);
		$display("test recall done");
		for (int c = 0; c < 4; c++) begin
			@(negedge ref_clk);
			addr_select_pins = 4'(c * 5 + 1);
			d = (c == 0) ? 8'hff : (c == 1) ? 8'h00 : 8'($urandom);
			xfer({4'ha, 2'h0, 2'(c)}, d, 1'b0, q);
			chk("tap", d, tap_sel[c]);
			xfer({4'h9, 2'h0, 2'(c)}, 8'h0, 1'b1, q);
			chk("wiper read", d, q);
		end
		$display("test wiper done");
		probe_id(id_of(addr_select_pins + 4'h1), 1'b1);
		probe_id({~DEV_ID, addr_select_pins}, 1'b1);
		// Unknown opcode after a valid id: no acknowledge
		u_qws_master.start();
		u_qws_master.byte_x(id_of(addr_select_pins), 1'b1, q, ak);
		u_qws_master.byte_x(8'h30, 1'b1, q, ak);
		chk("bad op", 8'h1, {7'h0, ak});
		u_qws_master.stop();
		$display("test address done");
		@(negedge ref_clk);
		wr_lock_n = 1'b0;
		xfer(8'hc6, 8'h3c, 1'b0, q);
		chk("locked busy", 8'h0, {7'h0, nv_busy});
		xfer(8'hb6, 8'h0, 1'b1, q);
		chk("locked store", INIT, q);
		@(negedge ref_clk);
		wr_lock_n = 1'b1;
		d = 8'($urandom);
		xfer(8'hc6, d, 1'b0, q);
		chk("busy", 8'h1, {7'h0, nv_busy});
		probe_id(id_of(addr_select_pins), 1'b1);
		for (int i = 0; i < 1000 && nv_busy; i++)
			@(negedge ref_clk);
		if (nv_busy !== 1'b0) begin
			chk("busy end", 8'h0, {7'h0, nv_busy});
			conclude();
		end
		xfer(8'hb6, 8'h0, 1'b1, q);
		chk("store read", d, q);
		$display("test stored done");
		conclude();
	end
endmodule // qws_top_tb_top
bind qws_top qws_top_monitor #(.STORE_INIT(STORE_INIT)) u_qws_top_monitor (
	.ref_clk, .rstn, .scl_clk, .sda_o, .sda_oe, .wr_lock_n, .tap_sel,
	.nv_busy);
`default_nettype wire
